//--- core/sram_host_pkg.sv
// constants, types and timing counts for the static ram host controller
package sram_host_pkg;

  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int WORDS = 2048;
  localparam int ARRAY_ROWS = 128;
  localparam int ARRAY_COLS = 128;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 2;

  // device timing figures in ns
  localparam int T_RC_NS = 120;
  localparam int T_AS_NS = 20;
  localparam int T_WP_NS = 70;
  localparam int T_AW_NS = 105;
  localparam int WRITE_RECOVERY_INTERVAL_NS = 5;
  localparam int T_DH_NS = 5;
  localparam int T_OHZ_NS = 40;

  // least time in whole cycles, never below one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  localparam int CNT_W = 4;
  localparam int RD_CYC = min_cycles(T_RC_NS) + SYNC_STAGES;
  localparam int AS_CYC = min_cycles(T_AS_NS);
  localparam int WP_CYC = max2(min_cycles(T_WP_NS), min_cycles(T_AW_NS) - AS_CYC);
  localparam int WR_CYC = max2(min_cycles(WRITE_RECOVERY_INTERVAL_NS), min_cycles(T_DH_NS));
  localparam int TURN_CYC = min_cycles(T_OHZ_NS);

  localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] AS_LOAD = CNT_W'(AS_CYC - 1);
  localparam logic [CNT_W-1:0] WP_LOAD = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LOAD = CNT_W'(WR_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_LOAD = CNT_W'(TURN_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  localparam logic [ADDR_W-1:0] ADDR_RESET = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_sel_n;
    logic out_en_n;
    logic write_en_n;
  } mem_pins_t;

  localparam mem_pins_t PINS_IDLE = '{addr: ADDR_RESET, chip_sel_n: 1'b1,
                                      out_en_n: 1'b1, write_en_n: 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_ADDR,
    ST_RD_ACCESS,
    ST_RD_TURN,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_RECOVER
  } host_state_t;

endpackage

//--- core/pin_sync.sv
// two-stage synchroniser for the data pins read back from the memory
`timescale 1ns/100ps
module pin_sync
  import sram_host_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic reset_i, // asynchronous reset, active high
  input wire logic [DATA_W-1:0] data_i, // raw pin levels
  output logic [DATA_W-1:0] data_o // synchronised levels
);

  logic [DATA_W-1:0] stage1_reg;
  logic [DATA_W-1:0] stage2_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1_reg <= DATA_RESET;
      stage2_reg <= DATA_RESET;
    end else begin
      stage1_reg <= data_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign data_o = stage2_reg;

endmodule

//--- core/sram_host.sv
// host controller driving a 2048 x 8 asynchronous static ram over its pins
`timescale 1ns/100ps

// Contract
// - host keeps write strobe high while chip select and output enable are low for reads.
// - host sets address before, or with, the chip select falling edge on reads.
// - host drives no data while memory may still drive at write start.
// - host drives no data while memory drives after a write with select low.
module sram_host
  import sram_host_pkg::*;
(
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic reset_i, // asynchronous reset, active high
  input wire logic req_valid_i, // request offered
  input wire mem_req_t req_i, // request: write flag, address, write data
  output logic req_ready_o, // controller idle, request taken when valid
  output logic done_o, // one-cycle pulse, access finished
  output logic [DATA_W-1:0] rdata_o, // read data, valid with done_o on reads
  output logic [ADDR_W-1:0] mem_addr_o, // memory address pins
  output logic mem_chip_sel_n_o, // memory chip select, active low
  output logic mem_out_en_n_o, // memory output enable, active low
  output logic mem_write_en_n_o, // memory write strobe, active low
  input wire logic [DATA_W-1:0] mem_data_i, // data pin levels
  output logic [DATA_W-1:0] mem_data_o, // data driven to the pins
  output logic mem_data_oe_o // high while the host drives the data pins
);

  host_state_t state_reg;
  host_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [DATA_W-1:0] data_sync;
  mem_pins_t pins_reg;
  mem_pins_t pins_next;
  logic [DATA_W-1:0] wdata_reg;
  logic data_oe_reg;
  logic ready_reg;
  logic done_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic accept;
  logic cnt_done;
  logic take_req;
  logic rd_last;

  // last counted cycle of the select window of a read
  function automatic logic read_last(input host_state_t s, input logic last);
    return last && (s == ST_RD_ACCESS);
  endfunction

  // host drives the data pins through the write pulse and one hold cycle
  function automatic logic drives_data(input host_state_t s);
    return (s == ST_WR_PULSE) || (s == ST_WR_RECOVER);
  endfunction

  // data pins come from outside the clock domain
  pin_sync u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .data_i(mem_data_i),
    .data_o(data_sync)
  );

  // ready is high only in idle, so a taken request always starts from idle
  assign accept = req_valid_i && ready_reg;
  assign take_req = (state_reg == ST_IDLE) && accept;
  assign cnt_done = (cnt_reg == CNT_ZERO);
  assign rd_last = read_last(state_reg, cnt_done);

  // sequencing of read and write cycles
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_done ? CNT_ZERO : cnt_reg - 1'b1;
    unique case (state_reg)
      ST_IDLE: begin
        // counter rests at zero while idle
        cnt_next = CNT_ZERO;
        if (accept) begin
          if (req_i.write) begin
            state_next = ST_WR_SETUP;
            cnt_next = AS_LOAD;
          end else begin
            state_next = ST_RD_ADDR; // address settles one cycle before select
          end
        end
      end
      ST_RD_ADDR: begin
        state_next = ST_RD_ACCESS;
        cnt_next = RD_LOAD; // a full cycle time plus pin synchroniser lag
      end
      ST_RD_ACCESS: begin
        // select window covers the access time and the synchroniser lag
        if (cnt_done) begin
          state_next = ST_RD_TURN;
          cnt_next = TURN_LOAD;
        end
      end
      ST_RD_TURN: begin
        // memory may still drive until its output turn-off time has passed
        if (cnt_done) begin
          state_next = ST_IDLE; // memory outputs are off before any write drive
        end
      end
      ST_WR_SETUP: begin
        // address settles before select and strobe fall
        if (cnt_done) begin
          state_next = ST_WR_PULSE;
          cnt_next = WP_LOAD;
        end
      end
      ST_WR_PULSE: begin
        // select and strobe stay low together for the whole pulse
        if (cnt_done) begin
          state_next = ST_WR_RECOVER;
          cnt_next = WR_LOAD;
        end
      end
      ST_WR_RECOVER: begin
        // strobes are high; write data stays on the pins for the hold time
        if (cnt_done) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // state and down counter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // pin levels follow the next state so they leave flip-flops directly
  always_comb begin
    pins_next = pins_reg;
    pins_next.chip_sel_n = 1'b1; // deselected between accesses
    pins_next.out_en_n = 1'b1;
    pins_next.write_en_n = 1'b1;
    // address changes only when a request is taken, so it holds while selected
    if (take_req) begin
      pins_next.addr = req_i.addr; // 11-bit word address
    end
    unique case (state_next)
      ST_RD_ACCESS: begin
        pins_next.chip_sel_n = 1'b0;
        pins_next.out_en_n = 1'b0;
        pins_next.write_en_n = 1'b1; // strobe stays high for a read
      end
      ST_WR_PULSE: begin
        // select and strobe fall together, so memory outputs stay off
        pins_next.chip_sel_n = 1'b0;
        pins_next.write_en_n = 1'b0; // write happens in the overlap
      end
      default: begin
        // both strobes rise together, ending the write at once
      end
    endcase
  end

  // pin register, idle levels under reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pins_reg <= PINS_IDLE;
    end else begin
      pins_reg <= pins_next;
    end
  end

  // data drive: only while selected for writing and during hold
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wdata_reg <= DATA_RESET;
      data_oe_reg <= 1'b0;
    end else begin
      if (take_req) begin
        wdata_reg <= req_i.wdata;
      end
      // output enable stays high in writes, so the memory never drives
      data_oe_reg <= drives_data(state_next);
    end
  end

  // handshake and read capture
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= DATA_RESET;
    end else begin
      ready_reg <= (state_next == ST_IDLE);
      done_reg <= rd_last ||
                  (cnt_done && (state_reg == ST_WR_RECOVER));
      if (rd_last) begin
        rdata_reg <= data_sync; // static data held while selected
      end
    end
  end

  // every output comes straight from a flip-flop
  assign req_ready_o = ready_reg;
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
  assign mem_addr_o = pins_reg.addr;
  assign mem_chip_sel_n_o = pins_reg.chip_sel_n;
  assign mem_out_en_n_o = pins_reg.out_en_n;
  assign mem_write_en_n_o = pins_reg.write_en_n;
  assign mem_data_o = wdata_reg;
  assign mem_data_oe_o = data_oe_reg;

endmodule

//--- verification/sram_host_checker.sv
// pin-level assertions for the static ram host controller
`timescale 1ns/100ps
module sram_host_checker
  import sram_host_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic req_valid_i, // offered
  input wire mem_req_t req_i, // request
  input wire logic req_ready_o, // ready
  input wire logic done_o, // done
  input wire logic [ADDR_W-1:0] mem_addr_o, // address pins
  input wire logic mem_chip_sel_n_o, // select
  input wire logic mem_out_en_n_o, // output enable
  input wire logic mem_write_en_n_o, // write strobe
  input wire logic mem_data_oe_o // host drive
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_rd_we;
    !mem_out_en_n_o |-> mem_write_en_n_o && !mem_chip_sel_n_o;
  endproperty
  a_rd_we: assert property (p_rd_we) else $error("read strobes wrong");
  property p_no_fight;
    !mem_out_en_n_o |-> !mem_data_oe_o;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus fight");
  property p_wr_start;
    $fell(mem_write_en_n_o) |-> $fell(mem_chip_sel_n_o) && mem_out_en_n_o;
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write start wrong");
  property p_wr_end;
    $rose(mem_write_en_n_o) |-> $rose(mem_chip_sel_n_o) && mem_data_oe_o ##1 !mem_data_oe_o;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write end wrong");
  property p_wr_pulse;
    $fell(mem_write_en_n_o) |-> (!mem_write_en_n_o && mem_data_oe_o)[*8] ##2
      $rose(mem_write_en_n_o);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse wrong");
  property p_addr_hold;
    !mem_chip_sel_n_o |-> $stable(mem_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_rd_len;
    $fell(mem_chip_sel_n_o) && !mem_out_en_n_o |-> ##14 $rose(mem_chip_sel_n_o);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length wrong");
  property p_desel;
    mem_chip_sel_n_o |-> mem_out_en_n_o && mem_write_en_n_o;
  endproperty
  a_desel: assert property (p_desel) else $error("strobe while deselected");
  property p_done_rd;
    req_valid_i && req_ready_o && !req_i.write |-> ##16 done_o;
  endproperty
  a_done_rd: assert property (p_done_rd) else $error("read done late");
  property p_done_wr;
    req_valid_i && req_ready_o && req_i.write |-> ##13 done_o;
  endproperty
  a_done_wr: assert property (p_done_wr) else $error("write done late");
endmodule
bind sram_host sram_host_checker sram_host_checker_i (.clk_i(clk_i), .reset_i(reset_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
  .mem_addr_o(mem_addr_o), .mem_chip_sel_n_o(mem_chip_sel_n_o),
  .mem_out_en_n_o(mem_out_en_n_o), .mem_write_en_n_o(mem_write_en_n_o),
  .mem_data_oe_o(mem_data_oe_o));

//--- verification/sram_model.sv
// behavioural model of the 2048 x 8 static ram
`timescale 1ns/100ps
module sram_model
  import sram_host_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i, // address
  input wire logic chip_sel_n_i, // select, low
  input wire logic out_en_n_i, // output enable, low
  input wire logic write_en_n_i, // write strobe, low
  input wire logic [DATA_W-1:0] data_i, // resolved pins
  output logic [DATA_W-1:0] data_o, // read data
  output logic data_oe_o // high while driving
);
  logic [DATA_W-1:0] mem_reg [WORDS];
  initial for (int i = 0; i < WORDS; i++) mem_reg[i] = 8'h00;
  always @* if (!chip_sel_n_i && !write_en_n_i) mem_reg[addr_i] = data_i;
  assign data_oe_o = !chip_sel_n_i && !out_en_n_i && write_en_n_i;
  assign data_o = mem_reg[addr_i];
endmodule

//--- verification/test_sram_host.sv
// self-checking testbench for the static ram host controller
`timescale 1ns/100ps
module test_sram_host;
  import sram_host_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  mem_req_t req_i = '0;
  logic req_ready_o, done_o, cs_n, oe_n, we_n, host_oe, mdl_oe;
  logic [DATA_W-1:0] rdata_o, host_d, mdl_d, pin;
  logic [DATA_W-1:0] last_pin = 8'h00;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] shadow [WORDS];
  logic [DATA_W:0] exp_q [$];
  logic [DATA_W:0] mon_e;
  logic [15:0] seed = 16'h0016;
  int num_errors = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  // undriven pins show the inverse of the last level
  assign pin = host_oe ? host_d : (mdl_oe ? mdl_d : ~last_pin);
  always @(posedge clk_i) last_pin <= pin;
  sram_host sram_host_i (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .mem_addr_o(mem_addr), .mem_chip_sel_n_o(cs_n), .mem_out_en_n_o(oe_n),
    .mem_write_en_n_o(we_n), .mem_data_i(pin), .mem_data_o(host_d), .mem_data_oe_o(host_oe));
  sram_model sram_model_i (.addr_i(mem_addr), .chip_sel_n_i(cs_n), .out_en_n_i(oe_n),
    .write_en_n_i(we_n), .data_i(pin), .data_o(mdl_d), .data_oe_o(mdl_oe));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_cnt(input string what, input int exp, input int got);
    n_checks++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_i <= '{write: wr, addr: a, wdata: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 100);
    req_valid_i <= 1'b0;
    if (n >= 100) num_errors++;
    exp_q.push_back({!wr, wr ? 8'h00 : shadow[a]});
    if (wr) shadow[a] = d;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (done_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] done expected none seen 1");
      end else begin
        mon_e = exp_q.pop_front();
        if (mon_e[8]) check8("rdata", mon_e[7:0], rdata_o);
      end
    end
  end
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < WORDS; i++) shadow[i] = 8'h00;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    xfer(1'b1, 11'h000, 8'h55);
    xfer(1'b1, 11'h7ff, 8'haa);
    xfer(1'b0, 11'h000, 8'h00);
    xfer(1'b0, 11'h7ff, 8'h00);
    $display("test boundary done");
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      xfer(1'b1, seed[10:0], seed[15:8]);
      xfer(1'b0, seed[10:0], 8'h00);
    end
    $display("test random done");
    xfer(1'b1, 11'h7ff, 8'h0f);
    xfer(1'b0, 11'h000, 8'h00);
    xfer(1'b0, 11'h7ff, 8'h00);
    $display("test overwrite done");
    repeat (30) @(posedge clk_i);
    check_cnt("pending", 0, exp_q.size());
    report_and_stop();
  end
endmodule
